// *** core/gcm_pkg.sv ***
// shared constants and types for the general counter measurement core
package gcm_pkg;

	localparam int          GCM_COUNT_W_DEF = 32;
	localparam int          GCM_SYNC_W      = 3;
	localparam logic        GCM_BANK_RST    = 1'h1;
	localparam logic [1:0]  GCM_EDGE_RISE   = 2'h1;
	localparam logic [1:0]  GCM_EDGE_FALL   = 2'h2;
	localparam logic [1:0]  GCM_EDGE_BOTH   = 2'h3;
	localparam int          GCM_SRC_BIT     = 0;
	localparam int          GCM_GATE_BIT    = 1;
	localparam int          GCM_AUX_BIT     = 2;

	// counting function, one-hot
	typedef enum logic [5:0] {
		MODE_SIMPLE     = 6'h01,
		MODE_GATED      = 6'h02,
		MODE_BUF_CUM    = 6'h04,
		MODE_BUF_NONCUM = 6'h08,
		MODE_QUAD       = 6'h10,
		MODE_PERIOD     = 6'h20
	} gcm_mode_t;

	typedef enum logic [1:0] {
		QUAD_ONE_STEP_MODE  = 2'h0,
		QUAD_TWO_STEP_MODE  = 2'h1,
		QUAD_FOUR_STEP_MODE = 2'h2
	} gcm_quad_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_RUN  = 3'h4
	} gcm_state_t;

endpackage : gcm_pkg

// *** core/gcm_edge_if.sv ***
// synchronised levels and edge strobes of source, gate and auxiliary lines
`timescale 1ns/1ps
`default_nettype none
interface gcm_edge_if;
	logic src_lvl;
	logic src_rise;
	logic src_fall;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;
	logic aux_lvl;
	logic aux_rise;
	logic aux_fall;

	modport producer (
		output src_lvl, src_rise, src_fall,
		output gate_lvl, gate_rise, gate_fall,
		output aux_lvl, aux_rise, aux_fall
	);
	modport consumer (
		input src_lvl, src_rise, src_fall,
		input gate_lvl, gate_rise, gate_fall,
		input aux_lvl, aux_rise, aux_fall
	);
endinterface : gcm_edge_if
`default_nettype wire

// *** core/gcm_input_sync.sv ***
// two-stage synchroniser and edge detector for the external lines
`timescale 1ns/1ps
`default_nettype none
module gcm_input_sync
	import gcm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       src_in,
	input  wire logic       gate_in,
	input  wire logic       aux_in,
	gcm_edge_if.producer    edges
);
	logic [GCM_SYNC_W-1:0] meta_q;
	logic [GCM_SYNC_W-1:0] sync_q;
	logic [GCM_SYNC_W-1:0] prev_q;
	wire  [GCM_SYNC_W-1:0] rise_w;
	wire  [GCM_SYNC_W-1:0] fall_w;

	// meta_q feeds only sync_q; edges compare the two settled stages
	// stages keep following the pins through reset, so a line already high when reset
	// ends gives no false edge; this needs reset held for three cycles
	always_ff @(posedge clk)
	begin
		meta_q <= {aux_in, gate_in, src_in};
		sync_q <= meta_q;
		prev_q <= sync_q;
	end

	assign rise_w          = sync_q & ~prev_q & {GCM_SYNC_W{~sys_rst}};
	assign fall_w          = ~sync_q & prev_q & {GCM_SYNC_W{~sys_rst}};
	assign edges.src_lvl   = sync_q[GCM_SRC_BIT];
	assign edges.src_rise  = rise_w[GCM_SRC_BIT];
	assign edges.src_fall  = fall_w[GCM_SRC_BIT];
	assign edges.gate_lvl  = sync_q[GCM_GATE_BIT];
	assign edges.gate_rise = rise_w[GCM_GATE_BIT];
	assign edges.gate_fall = fall_w[GCM_GATE_BIT];
	assign edges.aux_lvl   = sync_q[GCM_AUX_BIT];
	assign edges.aux_rise  = rise_w[GCM_AUX_BIT];
	assign edges.aux_fall  = fall_w[GCM_AUX_BIT];
endmodule : gcm_input_sync
`default_nettype wire

// *** core/gcm_counter_core.sv ***
// general counter core: event, gated, buffered, quadrature and period counting
`timescale 1ns/1ps
`default_nettype none
module gcm_counter_core #(
	parameter int COUNT_W = gcm_pkg::GCM_COUNT_W_DEF
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                src_in,
	input  wire logic                gate_in,
	input  wire logic                aux_in,
	input  wire logic                arm_cmd,
	input  wire logic                disarm_cmd,
	input  wire gcm_pkg::gcm_mode_t  mode_sel,
	input  wire gcm_pkg::gcm_quad_t  quad_mode,
	input  wire logic [1:0]          start_edge_sel,
	input  wire logic [1:0]          stop_edge_sel,
	input  wire logic                gate_invert,
	input  wire logic                buffered_save_enable,
	input  wire logic                load_strobe,
	input  wire logic [COUNT_W-1:0]  load_value,
	output logic [COUNT_W-1:0]       software_save_reg,
	output logic [COUNT_W-1:0]       hardware_save_reg,
	output logic                     latest_bank_flag,
	output logic                     counter_armed,
	output logic                     save_irq,
	output logic                     terminal_count
);
	import gcm_pkg::*;

	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		edge_hit = (sel[0] & r) | (sel[1] & f);
	endfunction : edge_hit

	function automatic logic [COUNT_W-1:0] bump(input logic [COUNT_W-1:0] v, input logic up);
		bump = up ? COUNT_W'(v + 1'b1) : COUNT_W'(v - 1'b1);
	endfunction : bump

	// steps per cycle
	// returns {step, up}; channel A is a, channel B is b
	function automatic logic [1:0] quad_step(input gcm_quad_t m, input logic a, input logic b,
		input logic ar, input logic af, input logic br, input logic bf);
		logic s;
		logic u;
		s = 1'b0;
		u = 1'b0;
		case (m)
			QUAD_ONE_STEP_MODE:
			begin
				s = (ar | af) & ~b;
				u = ar;
			end
			QUAD_TWO_STEP_MODE:
			begin
				s = ar | af;
				u = a ^ b;
			end
			QUAD_FOUR_STEP_MODE:
			begin
				s = ar | af | br | bf;
				u = (ar | af) ? (a ^ b) : ~(a ^ b);
			end
			default:
			begin
				s = 1'b0;
				u = 1'b0;
			end
		endcase
		quad_step = {s, u};
	endfunction : quad_step

	gcm_edge_if edges ();

	gcm_input_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.src_in  (src_in),
		.gate_in (gate_in),
		.aux_in  (aux_in),
		.edges   (edges)
	);

	gcm_state_t          state_q;
	gcm_state_t          state_d;
	logic [COUNT_W-1:0]  cnt_q;
	logic [COUNT_W-1:0]  cnt_d;
	logic [COUNT_W-1:0]  init_q;

	wire       running    = (state_q == ST_RUN);
	wire       waiting    = (state_q == ST_WAIT);
	wire       is_period  = (mode_sel == MODE_PERIOD);
	wire       is_quad    = (mode_sel == MODE_QUAD);
	wire       is_noncum  = (mode_sel == MODE_BUF_NONCUM);
	wire       is_buf     = (mode_sel == MODE_BUF_CUM) || is_noncum;
	wire       gate_on    = edges.gate_lvl ^ gate_invert;
	wire       gate_a_r   = gate_invert ? edges.gate_fall : edges.gate_rise;
	wire       gate_a_f   = gate_invert ? edges.gate_rise : edges.gate_fall;
	wire       start_evt  = edge_hit(start_edge_sel, gate_a_r, gate_a_f);
	wire       stop_evt   = edge_hit(stop_edge_sel, gate_a_r, gate_a_f);
	wire [1:0] quad_res   = quad_step(quad_mode, edges.src_lvl, edges.aux_lvl,
		edges.src_rise, edges.src_fall, edges.aux_rise, edges.aux_fall);
	wire       src_ok     = (mode_sel == MODE_GATED) ? (edges.src_rise & gate_on)
		: edges.src_rise;
	wire       step_en    = running & (is_quad ? quad_res[1] : src_ok);
	wire       step_up    = is_quad ? quad_res[0] : edges.aux_lvl;
	wire       buf_evt    = running & is_buf & start_evt;
	wire       per_done   = running & is_period & stop_evt;
	wire       save_evt   = buf_evt | per_done;
	wire       wrap       = step_en & (step_up ? (&cnt_q) : ~(|cnt_q));

	always_comb
	begin
		cnt_d = cnt_q;
		if (load_strobe)
			cnt_d = load_value;
		else if (buf_evt && is_noncum)
			cnt_d = step_en ? bump(init_q, step_up) : init_q;
		else if (waiting && is_period && start_evt)
			cnt_d = init_q;
		else if (step_en)
			cnt_d = bump(cnt_q, step_up);
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (arm_cmd)
					state_d = is_period ? ST_WAIT : ST_RUN;
			ST_WAIT:
				if (disarm_cmd)
					state_d = ST_IDLE;
				else if (start_evt)
					state_d = ST_RUN;
			ST_RUN:
				if (disarm_cmd || per_done)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= '0;
			init_q  <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (load_strobe)
				init_q <= load_value;
		end
	end

	// alternate banks; flag resets to 1 so the first save lands in hardware save
	wire to_hw = save_evt & (~buffered_save_enable | latest_bank_flag);
	wire to_sw = save_evt & buffered_save_enable & ~latest_bank_flag;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			software_save_reg <= '0;
			hardware_save_reg <= '0;
			latest_bank_flag  <= GCM_BANK_RST;
		end
		else
		begin
			if (!buffered_save_enable)
				software_save_reg <= cnt_d;
			else if (to_sw)
				software_save_reg <= cnt_q;
			if (to_hw)
				hardware_save_reg <= cnt_q;
			if (save_evt && buffered_save_enable)
				latest_bank_flag <= ~latest_bank_flag;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			counter_armed  <= 1'b0;
			save_irq       <= 1'b0;
			terminal_count <= 1'b0;
		end
		else
		begin
			counter_armed  <= (state_d != ST_IDLE);
			save_irq       <= buf_evt;
			terminal_count <= wrap & ~load_strobe;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_idle_no_count: assert property (
		(state_q == ST_IDLE) && !load_strobe |=> $stable(cnt_q))
		else $error("count moved while disarmed");
	a_simple_step_up: assert property (
		running && mode_sel == MODE_SIMPLE && edges.src_rise && edges.aux_lvl && !load_strobe
		|=> cnt_q == COUNT_W'($past(cnt_q) + 1'b1))
		else $error("simple count missed an up step");
	a_simple_step_down: assert property (
		running && mode_sel == MODE_SIMPLE && edges.src_rise && !edges.aux_lvl && !load_strobe
		|=> cnt_q == COUNT_W'($past(cnt_q) - 1'b1))
		else $error("down step wrong");
	a_gated_hold: assert property (
		running && mode_sel == MODE_GATED && !gate_on && !load_strobe |=> $stable(cnt_q))
		else $error("gated count moved with gate inactive");
	a_sw_mirror: assert property (
		!buffered_save_enable |=> software_save_reg == cnt_q)
		else $error("software save not tracking count");
	a_bank_latch: assert property (
		save_evt && buffered_save_enable |=> latest_bank_flag != $past(latest_bank_flag)
		&& (latest_bank_flag ? software_save_reg : hardware_save_reg) == $past(cnt_q))
		else $error("bank flag and saved value disagree");
	a_cum_latch: assert property (
		buf_evt && !is_noncum && !load_strobe && !step_en
		|=> cnt_q == $past(cnt_q) && $past(cnt_q) ==
		($past(buffered_save_enable) && latest_bank_flag ? software_save_reg : hardware_save_reg))
		else $error("cumulative latch wrong");
	a_irq_pulse: assert property (
		buf_evt |=> save_irq ##1 !save_irq || $past(buf_evt))
		else $error("interrupt pulse missing");
	a_noncum_reload: assert property (
		buf_evt && is_noncum && !step_en && !load_strobe |=> cnt_q == $past(init_q))
		else $error("interval reload wrong");
	a_quad_four_up: assert property (
		running && is_quad && quad_mode == QUAD_FOUR_STEP_MODE && edges.aux_rise
		&& edges.src_lvl && !edges.src_rise && !edges.src_fall && !load_strobe
		|=> cnt_q == COUNT_W'($past(cnt_q) + 1'b1))
		else $error("quadrature lead step wrong");
	a_period_once: assert property (
		per_done && !arm_cmd |=> state_q == ST_IDLE && !counter_armed)
		else $error("period did not disarm");
	a_disarm_stop: assert property (
		disarm_cmd && state_q != ST_IDLE |=> state_q == ST_IDLE && !counter_armed)
		else $error("disarm not taken");
	a_start_reload: assert property (
		waiting && is_period && start_evt && !disarm_cmd && !load_strobe
		|=> running && cnt_q == $past(init_q))
		else $error("interval start wrong");
	a_quad_four_down: assert property (
		running && is_quad && quad_mode == QUAD_FOUR_STEP_MODE && edges.aux_fall
		&& edges.src_lvl && !edges.src_rise && !edges.src_fall && !load_strobe
		|=> cnt_q == COUNT_W'($past(cnt_q) - 1'b1))
		else $error("quadrature lag step wrong");
	a_wrap_flag: assert property (
		step_en && !step_up && cnt_q == '0 && !load_strobe && !(buf_evt && is_noncum)
		|=> terminal_count && (&cnt_q))
		else $error("roll over not flagged");

	c_period_done: cover property (per_done);
	c_bank_swap: cover property (save_evt && buffered_save_enable && !latest_bank_flag);
	c_rollover: cover property (terminal_count && is_quad);
	c_disarm: cover property (disarm_cmd && running);
	c_gated_pause: cover property (running && mode_sel == MODE_GATED && edges.src_rise && !gate_on);
endmodule : gcm_counter_core
`default_nettype wire

// *** verif/gcm_ext_model.sv ***
// model of the external source, gate and auxiliary lines
`timescale 1ns/1ps
`default_nettype none
module gcm_ext_model (
	input  wire logic clk,
	output var logic  src_in,
	output var logic  gate_in,
	output var logic  aux_in
);
	initial
	begin
		src_in = 1'h0;
		gate_in = 1'h0;
		aux_in = 1'h1;
	end
	// slow pulses so every level outlasts the input synchroniser
	task automatic pulse(input int n);
		repeat (n)
		begin
			@(posedge clk) src_in <= 1'h1;
			repeat (4) @(posedge clk);
			src_in <= 1'h0;
			repeat (4) @(posedge clk);
		end
	endtask : pulse
	task automatic lvl_gate(input logic v);
		@(posedge clk) gate_in <= v;
		repeat (8) @(posedge clk);
	endtask : lvl_gate
	task automatic lvl_aux(input logic v);
		@(posedge clk) aux_in <= v;
		repeat (8) @(posedge clk);
	endtask : lvl_aux
	// one encoder cycle, A on source, B on auxiliary
	task automatic quad(input logic fwd);
		logic [3:0] a;
		logic [3:0] b;
		a = 4'h3;
		b = 4'h6;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk) src_in <= fwd ? a[i] : b[i];
			aux_in <= fwd ? b[i] : a[i];
			repeat (6) @(posedge clk);
		end
	endtask : quad
endmodule : gcm_ext_model
`default_nettype wire

// *** verif/gcm_counter_core_tb.sv ***
// self-checking bench for the general counter core
`timescale 1ns/1ps
`default_nettype none
module gcm_counter_core_tb;
	import gcm_pkg::*;
	logic       clk, sys_rst, arm_cmd, disarm_cmd, gate_invert, buffered_save_enable;
	logic       load_strobe, flag, armed, irq, tc;
	gcm_mode_t  mode_sel;
	gcm_quad_t  quad_mode;
	logic [1:0] start_edge_sel, stop_edge_sel;
	logic [7:0] load_value, sw, hw;
	wire logic  src, gate, aux;
	int         num_errors, cmp_count, irq_cnt, tc_cnt, cyc;

	gcm_ext_model gcm_ext_model_i (.clk(clk), .src_in(src), .gate_in(gate), .aux_in(aux));
	gcm_counter_core #(.COUNT_W(8)) gcm_counter_core_i (.clk(clk), .sys_rst(sys_rst),
		.src_in(src), .gate_in(gate), .aux_in(aux), .arm_cmd(arm_cmd),
		.disarm_cmd(disarm_cmd), .mode_sel(mode_sel), .quad_mode(quad_mode),
		.start_edge_sel(start_edge_sel), .stop_edge_sel(stop_edge_sel),
		.gate_invert(gate_invert), .buffered_save_enable(buffered_save_enable),
		.load_strobe(load_strobe), .load_value(load_value), .software_save_reg(sw),
		.hardware_save_reg(hw), .latest_bank_flag(flag), .counter_armed(armed),
		.save_irq(irq), .terminal_count(tc));

	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// one-cycle flags are counted at every edge they stand
	always @(posedge clk)
	begin
		cyc++;
		if (irq === 1'h1) irq_cnt++;
		if (tc === 1'h1) tc_cnt++;
		if (cyc >= 20000)
		begin
			num_errors++;
			finish_test();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// a running count may move between reads, so a third read settles it
	task automatic rd(input logic [7:0] exp, input string what);
		logic [7:0] a;
		logic [7:0] b;
		@(negedge clk) a = sw;
		@(negedge clk) b = sw;
		if (a !== b) @(negedge clk) b = sw;
		chk(b, exp, what);
	endtask : rd

	task automatic restart(input gcm_mode_t m, input logic [7:0] v);
		@(posedge clk) sys_rst <= 1'h1;
		mode_sel <= m;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk) load_strobe <= 1'h1;
		load_value <= v;
		@(posedge clk) load_strobe <= 1'h0;
		irq_cnt = 0;
		tc_cnt = 0;
	endtask : restart

	task automatic arm;
		@(posedge clk) arm_cmd <= 1'h1;
		@(posedge clk) arm_cmd <= 1'h0;
	endtask : arm

	task automatic test_simple;
		restart(MODE_SIMPLE, 8'h05);
		gcm_ext_model_i.pulse(1);
		rd(8'h05, "unarmed");
		arm();
		@(negedge clk) chk({7'h0, armed}, 8'h01, "armed");
		gcm_ext_model_i.pulse(3);
		rd(8'h08, "up count");
		gcm_ext_model_i.lvl_aux(1'h0);
		gcm_ext_model_i.pulse(1);
		rd(8'h07, "down count");
		$display("test simple done");
	endtask : test_simple

	task automatic test_gated;
		gcm_ext_model_i.lvl_aux(1'h1);
		restart(MODE_GATED, 8'h00);
		arm();
		gcm_ext_model_i.pulse(2);
		rd(8'h00, "gate closed");
		gcm_ext_model_i.lvl_gate(1'h1);
		gcm_ext_model_i.pulse(3);
		gcm_ext_model_i.lvl_gate(1'h0);
		gcm_ext_model_i.pulse(1);
		rd(8'h03, "gate open");
		$display("test gated done");
	endtask : test_gated

	task automatic test_buffered(input logic cum);
		@(posedge clk) buffered_save_enable <= 1'h1;
		restart(cum ? MODE_BUF_CUM : MODE_BUF_NONCUM, cum ? 8'h00 : 8'h0A);
		chk({7'h0, flag}, 8'h01, "bank reset");
		arm();
		gcm_ext_model_i.pulse(3);
		gcm_ext_model_i.lvl_gate(1'h1);
		chk(hw, cum ? 8'h03 : 8'h0D, "first save");
		chk({7'h0, flag}, 8'h00, "bank hw");
		gcm_ext_model_i.lvl_gate(1'h0);
		gcm_ext_model_i.pulse(2);
		gcm_ext_model_i.lvl_gate(1'h1);
		chk(sw, cum ? 8'h05 : 8'h0C, "second save");
		chk({7'h0, flag}, 8'h01, "bank sw");
		chk(irq_cnt[7:0], 8'h02, "irq count");
		gcm_ext_model_i.lvl_gate(1'h0);
		buffered_save_enable <= 1'h0;
		$display("test buffered done");
	endtask : test_buffered

	task automatic test_quad;
		logic [7:0] steps [3];
		steps = '{8'h01, 8'h02, 8'h04};
		gcm_ext_model_i.lvl_aux(1'h0);
		for (int m = 0; m < 3; m++)
		begin
			quad_mode <= gcm_quad_t'(m);
			restart(MODE_QUAD, 8'h00);
			arm();
			gcm_ext_model_i.quad(1'h1);
			rd(steps[m], "quad steps");
		end
		gcm_ext_model_i.quad(1'h0);
		gcm_ext_model_i.quad(1'h0);
		rd(8'hFC, "quad wrap");
		chk(tc_cnt[7:0], 8'h01, "wrap flag");
		$display("test quad done");
	endtask : test_quad

	task automatic test_period;
		gcm_ext_model_i.lvl_aux(1'h1);
		for (int e = 1; e < 4; e++)
		begin
			start_edge_sel <= 2'(e);
			stop_edge_sel <= 2'(e);
			restart(MODE_PERIOD, 8'h00);
			arm();
			gcm_ext_model_i.lvl_gate(1'h1);
			// both edges: the high phase is the interval, later pulses fall outside it
			if (e == 3) gcm_ext_model_i.pulse(4);
			gcm_ext_model_i.lvl_gate(1'h0);
			gcm_ext_model_i.pulse(4);
			gcm_ext_model_i.lvl_gate(1'h1);
			gcm_ext_model_i.lvl_gate(1'h0);
			gcm_ext_model_i.pulse(1);
			rd(8'h04, "period");
			chk({7'h0, armed}, 8'h00, "disarmed");
		end
		$display("test period done");
	endtask : test_period

	task automatic test_invert;
		@(posedge clk) gate_invert <= 1'h1;
		restart(MODE_GATED, 8'h10);
		arm();
		gcm_ext_model_i.pulse(2);
		gcm_ext_model_i.lvl_gate(1'h1);
		gcm_ext_model_i.pulse(1);
		rd(8'h12, "low gate active");
		@(posedge clk) disarm_cmd <= 1'h1;
		@(posedge clk) disarm_cmd <= 1'h0;
		gcm_ext_model_i.lvl_gate(1'h0);
		gcm_ext_model_i.pulse(2);
		rd(8'h12, "disarmed hold");
		chk({7'h0, armed}, 8'h00, "disarm");
		@(posedge clk) gate_invert <= 1'h0;
		$display("test invert done");
	endtask : test_invert

	initial
	begin
		{sys_rst, arm_cmd, disarm_cmd, gate_invert, buffered_save_enable, load_strobe} = 6'h20;
		mode_sel = MODE_SIMPLE;
		quad_mode = QUAD_FOUR_STEP_MODE;
		start_edge_sel = 2'h1;
		stop_edge_sel = 2'h1;
		load_value = 8'h00;
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		test_simple();
		test_gated();
		test_buffered(1'h1);
		test_buffered(1'h0);
		test_quad();
		test_period();
		test_invert();
		finish_test();
	end
endmodule : gcm_counter_core_tb
`default_nettype wire
